// [core/prhp_port.sv]
// parallel host port: command decode, continuous measurement, result queue and output
// Operation
// - strobe rise with continuous code starts measuring
// - repeat only while code and strobe persist
// - display-end mode waits display before repeating
// - verdict and data timing ignore ready mode
// - word held one cycle, strobe delayed, timed
// - queue results, block measuring until queue empties
// - verdict fails on any failure, level holds
// - up to 32 data words when enabled
// - up to two judgment words when enabled
// - handshake mode releases words on host request
// - handshake mode raises ready at measurement end
// - request rise drives word, strobe after settle
// - request fall drops the valid strobe
// - timeout on idle request or stuck request
// - timeout if request not renewed between words
// - ready drops fast after non-measure command
// - ready low while busy, high when accepting
// - commands honoured only in run mode
`timescale 1ns/100ps
module prhp_port #(
  parameter int MS_CYC = prhp_pkg::MS_CYCLES  // clocks per ms, shorten in simulation
) (
  input  wire logic                  clock,               // 250 MHz clock
  input  wire logic                  rst_n,               // synchronous reset, active low
  input  wire logic [7:0]            command_code_inputs, // command code pins
  input  wire logic                  execute_strobe,      // execute strobe pin
  input  wire logic                  host_data_request,   // host request pin
  input  wire logic                  run_mode,            // device is in run mode
  input  wire logic                  init_done,           // run-mode initialisation finished
  input  wire logic                  cmd_done,            // non-measure command finished
  input  wire prhp_pkg::prhp_cfg_t   cfg,                 // configuration
  input  wire prhp_pkg::prhp_meas_t  meas,                // measurement core events
  input  wire logic [31:0][15:0]     data_words,          // data words, held until next done
  output logic                       ready,               // ready indicator
  output logic                       meas_start,          // pulse: start one measurement
  output logic                       cmd_start,           // pulse: start non-measure command
  output logic [7:0]                 cmd_code,            // code of the accepted command
  output logic                       continuous_active,   // continuous measurement running
  output logic                       queue_blocked,       // measuring held for queue drain
  output logic [15:0]                result_word,         // result data outputs
  output logic                       result_valid,        // valid strobe
  output logic                       fail_verdict,        // overall judgment output
  output logic                       timeout_error,       // handshake timeout seen
  output logic                       config_error         // output timing rejected
);

  // filter used on each synchronised pin: accept a change once stages two and three agree
  function automatic logic [7:0] filt(input logic [7:0] s2, s3, prev);
    filt = (s2 == s3) ? s3 : prev;
  endfunction

  // front end: three-stage synchronisers and the millisecond tick
  logic [2:0]  ex_s_q, ex_s_d, rq_s_q, rq_s_d;   // strobe and request stages
  logic [7:0]  cd1_q, cd2_q, cd3_q;               // code stages
  logic [7:0]  code_f_q, code_f_d;                // filtered code
  logic        ex_f_q, ex_f_d, ex_p_q, rq_f_q, rq_f_d; // filtered levels, strobe history
  logic [17:0] ms_cnt_q, ms_cnt_d;                // tick prescaler
  logic        tick_q, tick_d;                    // one-cycle ms tick

  always_comb
  begin
    ex_s_d   = {ex_s_q[1:0], execute_strobe};
    rq_s_d   = {rq_s_q[1:0], host_data_request};
    code_f_d = filt(cd2_q, cd3_q, code_f_q);
    ex_f_d   = (ex_s_q[1] == ex_s_q[2]) ? ex_s_q[2] : ex_f_q;
    rq_f_d   = (rq_s_q[1] == rq_s_q[2]) ? rq_s_q[2] : rq_f_q;
    tick_d   = (ms_cnt_q == 18'(MS_CYC - 1));
    ms_cnt_d = tick_d ? 18'h00000 : ms_cnt_q + 18'h00001;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ex_s_q <= 3'h0; rq_s_q <= 3'h0;
      cd1_q <= 8'h00; cd2_q <= 8'h00; cd3_q <= 8'h00; code_f_q <= 8'h00;
      ex_f_q <= 1'b0; ex_p_q <= 1'b0; rq_f_q <= 1'b0;
      ms_cnt_q <= 18'h00000; tick_q <= 1'b0;
    end
    else
    begin
      ex_s_q <= ex_s_d; rq_s_q <= rq_s_d;
      cd1_q <= command_code_inputs; cd2_q <= cd1_q; cd3_q <= cd2_q;
      code_f_q <= code_f_d; ex_f_q <= ex_f_d; ex_p_q <= ex_f_q; rq_f_q <= rq_f_d;
      ms_cnt_q <= ms_cnt_d; tick_q <= tick_d;
    end
  end

  // queue state, declared ahead because control checks room
  localparam int QAW_W = prhp_pkg::QAW;
  logic [15:0] q_mem [prhp_pkg::QDEPTH];          // result word store
  logic [QAW_W-1:0] wr_q, wr_d, rd_q, rd_d;        // pointers
  logic [7:0]  cnt_q, cnt_d;                       // words held
  logic [7:0]  ld_rem_q, ld_rem_d, ld_idx_q, ld_idx_d, ld_nd_q, ld_nd_d; // loader
  logic [1:0]  jf_q, jf_d;                         // latched expression failures
  logic        wr_en, pop, flush;                  // queue strobes
  logic [15:0] wr_word;                            // word being loaded

  // control: command accept, continuous measurement, ready indicator
  typedef enum {C_IDLE, C_CMD, C_NEXT, C_MEAS, C_DISP, C_HOLD} prhp_ctl_t; // control states
  prhp_ctl_t  ctl_q, ctl_d;
  logic       cont_q, cont_d, ready_q, ready_d, block_q, block_d; // control flags
  logic       ms_q, ms_d, cs_q, cs_d, init_q, init_d;             // pulses, init seen
  logic [7:0] cc_q, cc_d;                                         // accepted code
  logic [1:0] rmode;                                              // effective ready mode
  logic       accept, keep_on, room;                              // decisions

  always_comb
  begin
    rmode   = cfg.handshake_on ? prhp_pkg::RDY_MEAS : cfg.ready_mode;
    accept  = ex_f_q && !ex_p_q && run_mode && ready_q;
    keep_on = cont_q && (code_f_q == prhp_pkg::CONT_CODE) && ex_f_q;
    room    = (9'(cnt_q) + 9'(ld_rem_q) + 9'(prhp_pkg::MAX_BURST)) <= 9'(prhp_pkg::QDEPTH);
    ctl_d = ctl_q; cont_d = cont_q; ready_d = ready_q; block_d = block_q;
    ms_d = 1'b0; cs_d = 1'b0; cc_d = cc_q; init_d = init_q;
    if (!init_q && init_done)
    begin
      init_d  = 1'b1;            // ready first rises once initialised
      ready_d = 1'b1;
    end
    case (ctl_q)
      C_IDLE:
        if (accept && ctl_q == C_IDLE)
        begin
          ready_d = 1'b0;
          cc_d    = code_f_q;
          if (code_f_q == prhp_pkg::CONT_CODE)
          begin
            cont_d = 1'b1;
            ctl_d  = C_NEXT;
          end
          else
          begin
            cs_d  = 1'b1;        // bank or model work starts
            ctl_d = C_CMD;
          end
        end
      C_CMD:
        if (cmd_done)
        begin
          ready_d = 1'b1;
          ctl_d   = C_IDLE;
        end
      C_NEXT:
        if (!keep_on)
        begin
          cont_d  = 1'b0;
          ready_d = 1'b1;
          ctl_d   = C_IDLE;
        end
        else if (!room)
        begin
          block_d = 1'b1;
          ctl_d   = C_HOLD;
        end
        else
        begin
          ms_d    = 1'b1;
          ready_d = 1'b0;
          ctl_d   = C_MEAS;
        end
      C_MEAS:
      begin
        if (meas.image_done && rmode == prhp_pkg::RDY_IMAGE)
          ready_d = 1'b1;
        if (meas.meas_done)
        begin
          if (rmode == prhp_pkg::RDY_MEAS)
            ready_d = 1'b1;
          ctl_d = (rmode == prhp_pkg::RDY_DISP) ? C_DISP : C_NEXT;
        end
      end
      C_DISP:
        if (meas.disp_done)
        begin
          ready_d = 1'b1;
          ctl_d   = C_NEXT;
        end
      C_HOLD:
        if (cnt_q == 8'h00 && ld_rem_q == 8'h00)
        begin
          block_d = 1'b0;        // queue drained
          ctl_d   = C_NEXT;
        end
      default: ctl_d = C_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ctl_q <= C_IDLE; cont_q <= 1'b0; ready_q <= 1'b0; block_q <= 1'b0;
      ms_q <= 1'b0; cs_q <= 1'b0; cc_q <= 8'h00; init_q <= 1'b0;
    end
    else
    begin
      ctl_q <= ctl_d; cont_q <= cont_d; ready_q <= ready_d; block_q <= block_d;
      ms_q <= ms_d; cs_q <= cs_d; cc_q <= cc_d; init_q <= init_d;
    end
  end

  // queue: loader copies one measurement's words, output side drains them
  always_comb
  begin
    ld_rem_d = ld_rem_q; ld_idx_d = ld_idx_q; ld_nd_d = ld_nd_q; jf_d = jf_q;
    wr_en    = (ld_rem_q != 8'h00) && (cnt_q != 8'(prhp_pkg::QDEPTH));
    wr_word  = (ld_idx_q < ld_nd_q) ? data_words[ld_idx_q[4:0]]
             : {15'h0000, jf_q[ld_idx_q[0] ^ ld_nd_q[0]]};
    if (wr_en)
    begin
      ld_rem_d = ld_rem_q - 8'h01;
      ld_idx_d = ld_idx_q + 8'h01;
    end
    if (meas.meas_done)
    begin
      // capped counts, zero when the port is not a destination
      ld_nd_d  = cfg.data_out_en ? ((8'(cfg.n_data) > prhp_pkg::MAX_DATA) ?
                 prhp_pkg::MAX_DATA : 8'(cfg.n_data)) : 8'h00;
      ld_rem_d = ld_nd_d + (cfg.judge_out_en ? ((8'(cfg.n_judge) > prhp_pkg::MAX_JUDGE) ?
                 prhp_pkg::MAX_JUDGE : 8'(cfg.n_judge)) : 8'h00);
      ld_idx_d = 8'h00;
      jf_d     = meas.expr_fail;
    end
    wr_d  = wr_en ? wr_q + QAW_W'(1) : wr_q;
    rd_d  = flush ? wr_q : (pop ? rd_q + QAW_W'(1) : rd_q);
    cnt_d = flush ? {7'h00, wr_en} : cnt_q + {7'h00, wr_en} - {7'h00, pop};
  end

  always_ff @(posedge clock)
  begin
    if (wr_en)
      q_mem[wr_q] <= wr_word;
    if (!rst_n)
    begin
      wr_q <= '0; rd_q <= '0; cnt_q <= 8'h00;
      ld_rem_q <= 8'h00; ld_idx_q <= 8'h00; ld_nd_q <= 8'h00; jf_q <= 2'h0;
    end
    else
    begin
      wr_q <= wr_d; rd_q <= rd_d; cnt_q <= cnt_d;
      ld_rem_q <= ld_rem_d; ld_idx_q <= ld_idx_d; ld_nd_q <= ld_nd_d; jf_q <= jf_d;
    end
  end

  // output: paced words or host handshake, shared ms timer
  typedef enum {O_IDLE, O_SETTLE, O_GATE, O_REST, H_REQ, H_SETTLE, H_GATE} prhp_out_t; // output
  prhp_out_t   out_q, out_d;
  logic [16:0] tmr_q, tmr_d;                        // ms since last clr (paced: since word start)
  logic [15:0] word_q, word_d;                      // word on the pins
  logic        gate_q, gate_d, to_q, to_d, cfe_q, cfe_d; // strobe, timeout, config fault
  logic        clr, bad, tmo;                       // timer restart, reject, timed out

  always_comb
  begin
    bad = (17'(cfg.settle_ms) + 17'(cfg.gate_ms)) >= 17'(cfg.cycle_ms);
    tmo = tmr_q >= 17'(cfg.timeout_ms);
    out_d = out_q; word_d = word_q; gate_d = gate_q; to_d = to_q;
    clr = 1'b0; pop = 1'b0; flush = 1'b0;
    if (ms_q)
      to_d = 1'b0;             // new measurement clears a stale timeout
    case (out_q)
      O_IDLE:
        if (cnt_q != 8'h00)
        begin
          clr = 1'b1;
          if (cfg.handshake_on)
            out_d = H_REQ;
          else if (!bad)
          begin
            pop    = 1'b1;     // last word stays on the pins
            word_d = q_mem[rd_q];
            out_d  = O_SETTLE;
          end
        end
      O_SETTLE:
        if (tmr_q >= 17'(cfg.settle_ms))
        begin
          gate_d = 1'b1;
          out_d  = O_GATE;
        end
      O_GATE:
        if (tmr_q >= 17'(cfg.settle_ms) + 17'(cfg.gate_ms))
        begin
          gate_d = 1'b0;
          out_d  = O_REST;
        end
      O_REST:
        if (tmr_q >= 17'(cfg.cycle_ms))
          out_d = O_IDLE;
      H_REQ:
        if (rq_f_q)
        begin
          pop    = 1'b1;
          word_d = q_mem[rd_q];
          clr    = 1'b1;
          out_d  = H_SETTLE;
        end
        else if (tmo)
        begin
          to_d  = 1'b1;
          flush = 1'b1;
          out_d = O_IDLE;
        end
      H_SETTLE:
        if (tmr_q >= 17'(cfg.settle_ms))
        begin
          gate_d = 1'b1;
          clr    = 1'b1;
          out_d  = H_GATE;
        end
      H_GATE:
        if (!rq_f_q)
        begin
          gate_d = 1'b0;
          clr    = 1'b1;
          out_d  = (cnt_q != 8'h00) ? H_REQ : O_IDLE;
        end
        else if (tmo)
        begin
          to_d   = 1'b1;
          gate_d = 1'b0;
          flush  = 1'b1;
          out_d  = O_IDLE;
        end
      default: out_d = O_IDLE;
    endcase
    cfe_d = bad && !cfg.handshake_on;
    tmr_d = clr ? 17'h00000 : ((tick_q && tmr_q != 17'h1ffff) ? tmr_q + 17'h00001 : tmr_q);
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      out_q <= O_IDLE; tmr_q <= 17'h00000; word_q <= prhp_pkg::WORD_RST;
      gate_q <= 1'b0; to_q <= 1'b0; cfe_q <= 1'b0;
    end
    else
    begin
      out_q <= out_d; tmr_q <= tmr_d; word_q <= word_d;
      gate_q <= gate_d; to_q <= to_d; cfe_q <= cfe_d;
    end
  end

  // overall verdict, level or one-shot, taken at measurement end in every ready mode
  logic        fail_q, fail_d, or_run_q, or_run_d; // verdict and one-shot running
  logic [15:0] or_tmr_q, or_tmr_d;                  // one-shot elapsed ms

  always_comb
  begin
    fail_d = fail_q; or_run_d = or_run_q; or_tmr_d = or_tmr_q;
    if (or_run_q && tick_q)
    begin
      or_tmr_d = or_tmr_q + 16'h0001;
      if (or_tmr_d >= cfg.or_time_ms)
      begin
        fail_d   = 1'b0;   // one-shot expires
        or_run_d = 1'b0;
      end
    end
    if (meas.meas_done)
    begin
      fail_d   = meas.region_fail || (|meas.expr_fail);
      or_run_d = cfg.or_oneshot;                        // level mode holds
      or_tmr_d = 16'h0000;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      fail_q <= 1'b0; or_run_q <= 1'b0; or_tmr_q <= 16'h0000;
    end
    else
    begin
      fail_q <= fail_d; or_run_q <= or_run_d; or_tmr_q <= or_tmr_d;
    end
  end

  // all outputs straight from flops
  assign ready             = ready_q;
  assign meas_start        = ms_q;
  assign cmd_start         = cs_q;
  assign cmd_code          = cc_q;
  assign continuous_active = cont_q;
  assign queue_blocked     = block_q;
  assign result_word       = word_q;
  assign result_valid      = gate_q;
  assign fail_verdict      = fail_q;
  assign timeout_error     = to_q;
  assign config_error      = cfe_q;
endmodule

// [core/prhp_pkg.sv]
// constants, configuration and status types for the parallel result handshake port
package prhp_pkg;
  localparam int CLK_PERIOD_NS = 4;                      // 250 MHz clock
  localparam int MS_NS = 1000000;                        // one millisecond in ns
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;      // clocks per ms tick
  localparam int TIMEOUT_DEFAULT_MS = 10000;             // 10 s handshake timeout
  localparam int CMD_SETUP_MS = 5;                       // host code setup before strobe
  localparam int CMD_HOLD_MS = 5;                        // host strobe hold, non-measure
  localparam logic [7:0] CONT_CODE = 8'h01;              // continuous-measurement code
  localparam int QDEPTH = 128;                           // result queue words
  localparam int QAW = 7;                                // queue pointer width
  localparam logic [7:0] MAX_DATA = 8'h20;               // data words per measurement
  localparam logic [7:0] MAX_JUDGE = 8'h02;              // judgment words per measurement
  localparam logic [7:0] MAX_BURST = 8'h22;              // worst-case words per measurement
  localparam logic [15:0] WORD_RST = 16'h0000;           // result word after reset
  localparam logic [1:0] RDY_IMAGE = 2'h0;               // ready at end of image input
  localparam logic [1:0] RDY_MEAS = 2'h1;                // ready at end of measurement
  localparam logic [1:0] RDY_DISP = 2'h2;                // ready at display end

  // user configuration, steady during operation
  typedef struct packed {
    logic        handshake_on;  // results paced by host request
    logic [1:0]  ready_mode;    // RDY_IMAGE / RDY_MEAS / RDY_DISP
    logic        data_out_en;   // data words go to the parallel port
    logic        judge_out_en;  // judgment words go to the parallel port
    logic [5:0]  n_data;        // configured data expressions
    logic [1:0]  n_judge;       // configured judgment expressions
    logic        or_oneshot;    // verdict as one-shot pulse, else level
    logic [15:0] or_time_ms;    // one-shot verdict on-time
    logic [15:0] settle_ms;     // word settle before valid strobe
    logic [15:0] gate_ms;       // valid strobe on-time
    logic [15:0] cycle_ms;      // output cycle per word
    logic [15:0] timeout_ms;    // handshake timeout
  } prhp_cfg_t;

  // events and results from the measurement core
  typedef struct packed {
    logic       image_done;     // pulse: image input finished
    logic       meas_done;      // pulse: measurement finished
    logic       disp_done;      // pulse: display processing finished
    logic       region_fail;    // any region failed
    logic [1:0] expr_fail;      // per judgment expression failure
  } prhp_meas_t;
endpackage

// [sim/prhp_host.sv]
// host model: drives command pins and fetches result words by request
`timescale 1ns/100ps
module prhp_host #(
  parameter int MS_CYC = 10  // clocks per ms
) (
  input  wire logic        clock,    // device clock
  input  wire logic        go,       // apply and hold a command while high
  input  wire logic [7:0]  code,     // command code to apply
  input  wire logic        fetch,    // fetch words by handshake while high
  input  wire logic        valid,    // device valid strobe
  input  wire logic [15:0] word,     // device result word
  output logic [7:0]       cmd_pins, // command code pins
  output logic             strobe,   // execute strobe pin
  output logic             req,      // data request pin
  output logic [15:0]      got,      // last fetched word
  output int               n_got     // words fetched so far
);
  // code first, strobe after setup, driven at fall
  initial
  begin
    cmd_pins = 8'h00;
    strobe = 1'b0;
    forever
    begin
      @(posedge clock);
      if (go)
      begin
        @(negedge clock);
        cmd_pins = code;
        repeat (prhp_pkg::CMD_SETUP_MS * MS_CYC) @(negedge clock);
        strobe = 1'b1;
        repeat (prhp_pkg::CMD_HOLD_MS * MS_CYC) @(negedge clock);
        while (go)
          @(posedge clock);
        @(negedge clock);
        strobe = 1'b0;
      end
    end
  end

  // one word per request, dropped only after valid is sampled
  initial
  begin
    req = 1'b0;
    got = 16'h0000;
    n_got = 0;
    forever
    begin
      @(posedge clock);
      if (fetch)
      begin
        @(negedge clock);
        req = 1'b1;
        while (!valid)
          @(posedge clock);
        @(negedge clock);
        got = word;
        n_got++;
        req = 1'b0;
        while (valid)
          @(negedge clock);
      end
    end
  end
endmodule

// [sim/prhp_port_checker.sv]
// pin-level assertions for the parallel result handshake port
`timescale 1ns/100ps
module prhp_port_checker #(
  parameter int MS_CYC = 10  // clocks per ms
) (
  input wire logic                 clock,             // device clock
  input wire logic                 rst_n,             // synchronous reset, active low
  input wire logic                 execute_strobe,    // execute strobe pin
  input wire logic                 host_data_request, // host request pin
  input wire logic                 run_mode,          // run mode level
  input wire prhp_pkg::prhp_cfg_t  cfg,               // configuration
  input wire prhp_pkg::prhp_meas_t meas,              // measurement events
  input wire logic                 ready,             // ready indicator
  input wire logic                 cmd_start,         // command start pulse
  input wire logic [15:0]          result_word,       // result word
  input wire logic                 result_valid,      // valid strobe
  input wire logic                 fail_verdict,      // overall judgment
  input wire logic                 timeout_error,     // handshake timeout
  input wire logic                 config_error       // timing rejected
);
  localparam int HALF_MS = MS_CYC / 2;  // 0.5 ms in clocks
  logic bad_cfg;                        // paced timing that cannot fit the cycle
  assign bad_cfg = !cfg.handshake_on &&
                   (17'(cfg.settle_ms) + 17'(cfg.gate_ms) >= 17'(cfg.cycle_ms));

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // active reset is the trigger, so never disabled
  reset_quiet_a: assert property (disable iff (1'b0) !rst_n |=>
    !ready && !result_valid && !fail_verdict && result_word == 16'h0000)
    else $error("reset state");
  ready_drop_a: assert property ($rose(execute_strobe) && ready && run_mode
    |-> ##[1:HALF_MS] !ready) else $error("ready kept");
  busy_ready_a: assert property (cmd_start |-> !ready)
    else $error("ready high");
  run_only_a: assert property (!run_mode [*3] |=> !cmd_start)
    else $error("run mode");
  // flag lags bad_cfg by one edge
  cfg_reject_a: assert property (bad_cfg && $past(bad_cfg) && $past(rst_n) |-> config_error)
    else $error("not rejected");
  no_word_a: assert property (config_error |-> !result_valid)
    else $error("word sent");
  word_hold_a: assert property (result_valid |-> $stable(result_word))
    else $error("word moved");
  hs_release_a: assert property (cfg.handshake_on && $fell(host_data_request)
    |-> ##[1:6] !result_valid) else $error("valid kept");
  hs_request_a: assert property (cfg.handshake_on && $rose(result_valid)
    |-> host_data_request) else $error("no request");
  verdict_set_a: assert property (meas.meas_done && !cfg.or_oneshot |=>
    fail_verdict == $past(meas.region_fail || (|meas.expr_fail)))
    else $error("bad verdict");
  verdict_hold_a: assert property (!meas.meas_done && !cfg.or_oneshot |=>
    $stable(fail_verdict)) else $error("verdict moved");

  cmd_seen_c: cover property (cmd_start);
  hs_word_c: cover property (cfg.handshake_on && $fell(result_valid));
  timeout_c: cover property ($rose(timeout_error));
endmodule

bind prhp_port prhp_port_checker #(.MS_CYC(MS_CYC)) u_prhp_port_checker (
  .clock(clock), .rst_n(rst_n), .execute_strobe(execute_strobe),
  .host_data_request(host_data_request), .run_mode(run_mode), .cfg(cfg), .meas(meas),
  .ready(ready), .cmd_start(cmd_start), .result_word(result_word),
  .result_valid(result_valid), .fail_verdict(fail_verdict),
  .timeout_error(timeout_error), .config_error(config_error));

// [sim/prhp_port_tb.sv]
// bench: host model on pins, bench plays the measurement core
`timescale 1ns/100ps
module prhp_port_tb;
  localparam int MS = 10;               // short ms for simulation
  logic                clock, rst_n, run_mode, init_done, cmd_done, go, fetch;
  logic [7:0]          code, cmd_pins, cmd_code;
  logic                strobe, req, ready, meas_start, cmd_start, result_valid;
  logic                fail_verdict, timeout_error, config_error, v_q;
  logic [15:0]         result_word, got;
  logic [31:0][15:0]   dw;              // data words from the core
  logic [15:0]         seen[$], expw[$];
  prhp_pkg::prhp_cfg_t cfg;
  prhp_pkg::prhp_meas_t meas;
  int                  n_fail, checks, n_start, n_cmd, n_got, b;

  prhp_port #(.MS_CYC(MS)) u_prhp_port (.clock(clock), .rst_n(rst_n),
    .command_code_inputs(cmd_pins), .execute_strobe(strobe), .host_data_request(req),
    .run_mode(run_mode), .init_done(init_done), .cmd_done(cmd_done), .cfg(cfg),
    .meas(meas), .data_words(dw), .ready(ready), .meas_start(meas_start),
    .cmd_start(cmd_start), .cmd_code(cmd_code), .continuous_active(),
    .queue_blocked(), .result_word(result_word), .result_valid(result_valid),
    .fail_verdict(fail_verdict), .timeout_error(timeout_error),
    .config_error(config_error));
  prhp_host #(.MS_CYC(MS)) u_prhp_host (.clock(clock), .go(go), .code(code),
    .fetch(fetch), .valid(result_valid), .word(result_word), .cmd_pins(cmd_pins),
    .strobe(strobe), .req(req), .got(got), .n_got(n_got));

  initial
  begin
    clock = 1'b0;
    forever
      #2 clock = ~clock;
  end

  // count starts, record each word at its valid rise
  always @(posedge clock)
  begin
    v_q <= result_valid;
    if (result_valid === 1'b1 && v_q !== 1'b1)
      seen.push_back(result_word);
    if (meas_start === 1'b1)
      n_start++;
    if (cmd_start === 1'b1)
      n_cmd++;
  end

  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  task automatic final_report();
    if (n_fail == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // bounded wait on a counter; running out ends the run
  task automatic wait_cnt(ref int c, input int tgt, input int lim);
    for (int n = 0; n < lim && c < tgt; n++)
      @(negedge clock);
    if (c < tgt)
    begin
      n_fail++;
      $display("CHECK FAILED %0t wait ran out", $time);
      final_report();
    end
  endtask

  task automatic wait_hi(ref logic s, input int lim);
    for (int n = 0; n < lim && s !== 1'b1; n++)
      @(negedge clock);
    chk(s === 1'b1, "flag late");
    if (s !== 1'b1)
      final_report();
  endtask

  // spacing covers the last strobe hold
  task automatic issue(input logic [7:0] c);
    repeat (6 * MS) @(negedge clock);
    code = c;
    go = 1'b1;
  endtask

  // one measurement: image, result, then display end
  task automatic measure(input logic [1:0] ef, input int tgt, input logic last);
    int k;
    wait_cnt(n_start, tgt, 400);
    if (last)
      go = 1'b0;
    repeat (last ? 60 : 8) @(negedge clock);
    meas.image_done = 1'b1;
    @(negedge clock);
    meas.image_done = 1'b0;
    meas.meas_done = 1'b1;
    meas.expr_fail = ef;
    @(negedge clock);
    meas.meas_done = 1'b0;
    k = n_start;
    repeat (8) @(negedge clock);
    chk(fail_verdict === (|ef), "verdict");
    chk(n_start == k, "display wait");
    meas.disp_done = 1'b1;
    @(negedge clock);
    meas.disp_done = 1'b0;
  endtask

  initial
  begin
    {rst_n, run_mode, init_done, cmd_done, go, fetch} = 6'h00;
    code = 8'h00;
    v_q = 1'b0;
    meas = '0;
    for (int i = 0; i < 32; i++)
      dw[i] = 16'h1000 | 16'(i);
    cfg = '0;
    cfg.ready_mode = prhp_pkg::RDY_DISP;
    {cfg.data_out_en, cfg.judge_out_en} = 2'h3;
    {cfg.n_data, cfg.n_judge} = {6'h02, 2'h1};
    {cfg.settle_ms, cfg.gate_ms, cfg.cycle_ms} = {16'h0001, 16'h0001, 16'h0004};
    cfg.timeout_ms = 16'h0014;
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    chk(ready === 1'b0 && result_word === 16'h0000, "reset state");
    init_done = 1'b1;
    wait_hi(ready, 10);
    issue(8'h10);
    repeat (120) @(negedge clock);
    go = 1'b0;
    repeat (10) @(negedge clock);
    chk(n_cmd == 0 && ready === 1'b1, "run mode");
    run_mode = 1'b1;
    issue(8'h10);
    wait_cnt(n_cmd, 1, 200);
    chk(cmd_code === 8'h10 && ready === 1'b0, "command accept");
    go = 1'b0;
    cmd_done = 1'b1;
    @(negedge clock);
    cmd_done = 1'b0;
    repeat (3) @(negedge clock);
    chk(ready === 1'b1, "ready after command");
    for (int p = 0; p < 2; p++)
    begin
      cfg.data_out_en = (p == 0);
      seen.delete();
      expw.delete();
      for (int m = 0; m < 2; m++)
      begin
        if (p == 0)
          expw.push_back(dw[0]);
        if (p == 0)
          expw.push_back(dw[1]);
        expw.push_back({15'h0000, m == 0});
      end
      issue(prhp_pkg::CONT_CODE);
      b = n_start;
      measure(2'b01, b + 1, 1'b0);
      measure(2'b00, b + 2, 1'b1);
      repeat (10) @(negedge clock);
      chk(n_start == b + 2 && ready === 1'b1, "continuous end");
      for (int n = 0; n < 800 && seen.size() < expw.size(); n++)
        @(negedge clock);
      chk(seen.size() == expw.size(), "word count");
      if (seen.size() != expw.size())
        final_report();
      for (int i = 0; i < expw.size() && i < seen.size(); i++)
        chk(seen[i] === expw[i], "word value");
    end
    cfg.handshake_on = 1'b1;
    {cfg.data_out_en, cfg.judge_out_en, cfg.n_data} = {2'h2, 6'h01};
    issue(prhp_pkg::CONT_CODE);
    b = n_start;
    measure(2'b10, b + 1, 1'b1);
    repeat (20) @(negedge clock);
    chk(ready === 1'b1 && result_valid === 1'b0, "handshake idle");
    fetch = 1'b1;
    wait_cnt(n_got, 1, 300);
    fetch = 1'b0;
    chk(got === dw[0] && timeout_error === 1'b0, "handshake word");
    cfg.timeout_ms = 16'h0003;
    issue(prhp_pkg::CONT_CODE);
    b = n_start;
    measure(2'b00, b + 1, 1'b1);
    wait_hi(timeout_error, 100);
    cfg.handshake_on = 1'b0;
    {cfg.settle_ms, cfg.gate_ms} = {16'h0002, 16'h0002};
    wait_hi(config_error, 10);
    final_report();
  end
endmodule
